// ---- design/autoneg_expansion_next_page_regs.sv ----
// auto-negotiation expansion status and next page transmit registers
// Behaviour
// RULE1 - expansion reserved bits 15:5 read zero
// RULE2 - controller writes reserved bits with defaults; the station zeroes only transmit bit 14, not expansion bits 15:5
// RULE3 - override-writable bits gated by override control
// RULE4 - parallel detection fault sets fault flag
// RULE5 - fault flag latches high
// RULE6 - partner next page bit sets partner flag
// RULE7 - local next page ability reads one
// RULE8 - new stored page sets page received
// RULE9 - page received clears on expansion read
// RULE10 - valid pulse bursts set partner able
// RULE11 - more pages bit drives outgoing page
// RULE12 - next pages only if partner supports
// RULE13 - transmit bit 14 reads zero
// RULE14 - message page bit, reset one
// RULE15 - second acknowledge bit, reset zero
// RULE16 - eleven-bit code field, reset 001h
// RULE17 - toggle inverts per sent page
// RULE18 - code field placed into outgoing page
// RULE19 - fault flag clears on read unless present
`timescale 1ns/1ps
`default_nettype none
module autoneg_expansion_next_page_regs
   import an_regs_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // management register access
   input  wire logic [4:0]  mgmt_addr,
   input  wire logic        mgmt_wr,
   input  wire logic        mgmt_rd,
   input  wire logic [15:0] mgmt_wdata,
   output logic      [15:0] mgmt_rdata,
   // override control level
   input  wire logic        override_en,
   // events from the negotiation engine
   input  wire logic        pd_fault_evt,
   input  wire logic        lp_page_stored,
   input  wire logic        lp_more_pages,
   input  wire logic        flp_valid,
   input  wire logic        base_page_sent,
   input  wire logic        base_bit11,
   input  wire logic        np_page_sent,
   // outgoing next page code word and next page permission
   output logic      [15:0] np_tx_word,
   output logic             np_tx_allowed
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic        more_pages_flag_reg;
   logic        more_pages_flag_next;
   logic        message_page_flag_reg;
   logic        message_page_flag_next;
   logic        second_acknowledge_reg;
   logic        second_acknowledge_next;
   logic [10:0] code_reg;
   logic [10:0] code_next;
   logic [10:0] exp_rsvd_reg;
   logic [10:0] exp_rsvd_next;
   logic        lp_np_able_reg;
   logic        lp_np_able_next;
   logic        lp_an_able_reg;
   logic        lp_an_able_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic        exp_rd;
   logic        pd_fault;
   logic        page_rx;
   logic        toggle;

   assign exp_rd = mgmt_rd && (mgmt_addr == EXPANSION_ADDR);

   // ----------------------------------------------------------------
   // latching status bits and toggle sequencer
   // ----------------------------------------------------------------
   // a fault still present at the read sets again in the same cycle
   latch_high_bit u_pd_fault (
      .clk      (clk),
      .arst_n   (arst_n),
      .set_in   (pd_fault_evt),       // [RULE4] [RULE5] [RULE19]
      .clear_rd (exp_rd),
      .flag     (pd_fault)
   );

   latch_high_bit u_page_rx (
      .clk      (clk),
      .arst_n   (arst_n),
      .set_in   (lp_page_stored),     // [RULE8]
      .clear_rd (exp_rd),             // [RULE9]
      .flag     (page_rx)
   );

   np_toggle_gen u_toggle (
      .clk            (clk),
      .arst_n         (arst_n),
      .base_page_sent (base_page_sent),
      .base_bit11     (base_bit11),
      .np_page_sent   (np_page_sent),  // [RULE17]
      .toggle         (toggle)
   );

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   always_comb begin
      more_pages_flag_next    = more_pages_flag_reg;
      message_page_flag_next  = message_page_flag_reg;
      second_acknowledge_next = second_acknowledge_reg;
      code_next               = code_reg;
      exp_rsvd_next           = exp_rsvd_reg;
      lp_np_able_next         = lp_np_able_reg;
      lp_an_able_next         = flp_valid;                 // [RULE10]
      if (lp_page_stored) begin
         lp_np_able_next = lp_more_pages;                  // [RULE6]
      end
      if (mgmt_wr && (mgmt_addr == NP_TRANSMIT_ADDR)) begin
         more_pages_flag_next    = mgmt_wdata[NP_MORE];     // [RULE11]
         message_page_flag_next  = mgmt_wdata[NP_MSG_PAGE]; // [RULE14]
         second_acknowledge_next = mgmt_wdata[NP_SECOND_ACKNOWLEDGE];     // [RULE15]
         code_next               = mgmt_wdata[NP_CODE_W-1:0]; // [RULE16]
      end
      // hidden state only; reserved bits never reach the read path
      if (mgmt_wr && (mgmt_addr == EXPANSION_ADDR) && override_en) begin
         exp_rsvd_next = mgmt_wdata[15:EXP_RSVD_LSB];      // [RULE3]
      end
   end

   // ----------------------------------------------------------------
   // read mux, registered
   // ----------------------------------------------------------------
   always_comb begin
      rdata_next = rdata_reg;
      if (mgmt_rd) begin
         rdata_next = 16'h0000;                            // [RULE1] [RULE13]
         case (mgmt_addr)
            EXPANSION_ADDR: begin
               rdata_next[EXP_PD_FAULT]   = pd_fault;
               rdata_next[EXP_LP_NP_ABLE] = lp_np_able_reg;
               rdata_next[EXP_NP_ABLE]    = 1'b1;          // [RULE7]
               rdata_next[EXP_PAGE_RX]    = page_rx;
               rdata_next[EXP_LP_AN_ABLE] = lp_an_able_reg;
            end
            NP_TRANSMIT_ADDR: begin
               rdata_next = np_tx_word;
            end
            default: begin
               rdata_next = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         more_pages_flag_reg    <= NP_MORE_RESET;
         message_page_flag_reg  <= NP_MSG_RESET;
         second_acknowledge_reg <= NP_SECOND_ACKNOWLEDGE_RESET;
         code_reg               <= NP_CODE_RESET;
         exp_rsvd_reg           <= EXP_RSVD_RESET;
         lp_np_able_reg         <= 1'b0;
         lp_an_able_reg         <= 1'b0;
         rdata_reg              <= 16'h0000;
      end else begin
         more_pages_flag_reg    <= more_pages_flag_next;
         message_page_flag_reg  <= message_page_flag_next;
         second_acknowledge_reg <= second_acknowledge_next;
         code_reg               <= code_next;
         exp_rsvd_reg           <= exp_rsvd_next;
         lp_np_able_reg         <= lp_np_able_next;
         lp_an_able_reg         <= lp_an_able_next;
         rdata_reg              <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // outgoing code word
   // ----------------------------------------------------------------
   always_comb begin
      np_tx_word              = 16'h0000;
      np_tx_word[NP_MORE]     = more_pages_flag_reg;       // [RULE11]
      np_tx_word[NP_RSVD]     = 1'b0;                      // [RULE13]
      np_tx_word[NP_MSG_PAGE] = message_page_flag_reg;
      np_tx_word[NP_SECOND_ACKNOWLEDGE]     = second_acknowledge_reg;
      np_tx_word[NP_TOGGLE]   = toggle;
      np_tx_word[NP_CODE_W-1:0] = code_reg;                // [RULE18]
   end

   // the engine must not send next pages to a partner without them
   assign np_tx_allowed = lp_np_able_reg;                  // [RULE12]
   assign mgmt_rdata    = rdata_reg;
endmodule
`default_nettype wire

// ---- design/an_regs_pkg.sv ----
// constants for the auto-negotiation expansion and next page transmit registers
package an_regs_pkg;
   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [4:0]  EXPANSION_ADDR   = 5'h06;
   localparam logic [4:0]  NP_TRANSMIT_ADDR = 5'h07;
   localparam logic [4:0]  EXT_CTRL_ADDR    = 5'h10;
   localparam int          OVERRIDE_BIT     = 15;
   // ----------------------------------------------------------------
   // expansion register fields
   // ----------------------------------------------------------------
   localparam int          EXP_PD_FAULT     = 4;
   localparam int          EXP_LP_NP_ABLE   = 3;
   localparam int          EXP_NP_ABLE      = 2;
   localparam int          EXP_PAGE_RX      = 1;
   localparam int          EXP_LP_AN_ABLE   = 0;
   localparam int          EXP_RSVD_LSB     = 5;
   localparam logic [10:0] EXP_RSVD_RESET   = 11'h000;
   // ----------------------------------------------------------------
   // next page transmit fields
   // ----------------------------------------------------------------
   localparam int          NP_MORE          = 15;
   localparam int          NP_RSVD          = 14;
   localparam int          NP_MSG_PAGE      = 13;
   localparam int          NP_SECOND_ACKNOWLEDGE          = 12;
   localparam int          NP_TOGGLE        = 11;
   localparam int          NP_CODE_W        = 11;
   localparam int          BASE_TOGGLE_BIT  = 11;
   localparam logic        NP_MORE_RESET    = 1'b0;
   localparam logic        NP_MSG_RESET     = 1'b1;
   localparam logic        NP_SECOND_ACKNOWLEDGE_RESET    = 1'b0;
   localparam logic [10:0] NP_CODE_RESET    = 11'h001;
endpackage

// ---- design/latch_high_bit.sv ----
// latching-high status bit cleared by a register read
`timescale 1ns/1ps
`default_nettype none
module latch_high_bit (
   // clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // event and clear
   input  wire logic set_in,
   input  wire logic clear_rd,
   // state
   output logic      flag
);
   logic flag_reg;
   logic flag_next;

   // set wins over a clear in the same cycle so no event is lost
   always_comb begin
      flag_next = flag_reg;
      if (clear_rd) begin
         flag_next = 1'b0;
      end
      if (set_in) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag = flag_reg;
endmodule
`default_nettype wire

// ---- design/np_toggle_gen.sv ----
// toggle bit sequencer for transmitted next page code words
`timescale 1ns/1ps
`default_nettype none
module np_toggle_gen (
   // clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // page events
   input  wire logic base_page_sent,
   input  wire logic base_bit11,
   input  wire logic np_page_sent,
   // toggle value of the next page to send
   output logic      toggle
);
   logic tog_reg;
   logic tog_next;

   always_comb begin
      tog_next = tog_reg;
      if (base_page_sent) begin
         tog_next = ~base_bit11;
      end else if (np_page_sent) begin
         tog_next = ~tog_reg;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tog_reg <= 1'b0;
      end else begin
         tog_reg <= tog_next;
      end
   end

   assign toggle = tog_reg;
endmodule
`default_nettype wire

// ---- tb/an_regs_checker.sv ----
// port assertions for the expansion and next page transmit registers
`timescale 1ns/1ps
`default_nettype none
module an_regs_checker
   import an_regs_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // management access
   input wire logic        mgmt_wr,
   input wire logic        mgmt_rd,
   input wire logic [4:0]  mgmt_addr,
   input wire logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata,
   // engine side
   input wire logic        override_en,
   input wire logic        pd_fault_evt,
   input wire logic        lp_page_stored,
   input wire logic        lp_more_pages,
   input wire logic        flp_valid,
   input wire logic        base_page_sent,
   input wire logic        base_bit11,
   input wire logic        np_page_sent,
   input wire logic [15:0] np_tx_word,
   input wire logic        np_tx_allowed
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire exp_read = mgmt_rd && mgmt_addr == EXPANSION_ADDR;
   wire np_write = mgmt_wr && mgmt_addr == NP_TRANSMIT_ADDR;
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   rsvd_zero_a: assert property (
      exp_read |=> mgmt_rdata[15:5] == 11'h000)
      else $error("expansion reserved bits not zero");
   np_able_a: assert property (
      exp_read |=> mgmt_rdata[EXP_NP_ABLE])
      else $error("local next page ability not one");
   fault_latch_a: assert property (
      pd_fault_evt ##1 exp_read |=> mgmt_rdata[EXP_PD_FAULT])
      else $error("fault flag not latched");
   fault_clear_a: assert property (
      (exp_read && !pd_fault_evt) ##1 (!pd_fault_evt && !mgmt_rd)
      ##1 (exp_read && !pd_fault_evt) |=> !mgmt_rdata[EXP_PD_FAULT])
      else $error("fault flag not cleared");
   page_set_a: assert property (
      lp_page_stored ##1 exp_read |=> mgmt_rdata[EXP_PAGE_RX])
      else $error("page received not set");
   page_clear_a: assert property (
      (exp_read && !lp_page_stored) ##1 (!lp_page_stored && !mgmt_rd)
      ##1 (exp_read && !lp_page_stored) |=> !mgmt_rdata[EXP_PAGE_RX])
      else $error("page flag stuck");
   np_allow_a: assert property (
      lp_page_stored && lp_more_pages |-> ##[1:2] np_tx_allowed)
      else $error("next pages not allowed");
   np_deny_a: assert property (
      lp_page_stored && !lp_more_pages |=> !np_tx_allowed)
      else $error("next pages allowed without partner support");
   an_able_a: assert property (
      flp_valid [*2] ##1 exp_read |=> mgmt_rdata[EXP_LP_AN_ABLE])
      else $error("partner able flag not set");
   tx_rsvd_a: assert property (
      np_tx_word[NP_RSVD] == 1'b0)
      else $error("outgoing bit 14 not zero");
   tx_fields_a: assert property (
      np_write |=> (np_tx_word & 16'hB7FF) == ($past(mgmt_wdata) & 16'hB7FF))
      else $error("outgoing word fields wrong");
   toggle_flip_a: assert property (
      np_page_sent && !base_page_sent |=> np_tx_word[NP_TOGGLE] != $past(np_tx_word[NP_TOGGLE]))
      else $error("toggle did not invert");
   toggle_base_a: assert property (
      base_page_sent |=> np_tx_word[NP_TOGGLE] == !$past(base_bit11))
      else $error("first toggle wrong");
   cover property (exp_read ##1 mgmt_rdata[EXP_PAGE_RX]);
   cover property (np_page_sent);
   cover property (np_write);
endmodule
bind autoneg_expansion_next_page_regs an_regs_checker chk_u (.*);
`default_nettype wire

// ---- tb/mgmt_station.sv ----
// station management controller model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module mgmt_station
   import an_regs_pkg::*;
(
   // clock
   input  wire logic        clk,
   // register access
   output logic      [4:0]  mgmt_addr,
   output logic             mgmt_wr,
   output logic             mgmt_rd,
   output logic      [15:0] mgmt_wdata
);
   initial begin
      mgmt_addr = 5'h00;
      mgmt_wr = 1'b0;
      mgmt_rd = 1'b0;
      mgmt_wdata = 16'h0000;
   end
   // idle lines carry inverted values so stale data never looks valid
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      mgmt_addr <= a;
      mgmt_wdata <= (a == NP_TRANSMIT_ADDR) ? {d[15], 1'b0, d[13:0]} : d;
      mgmt_wr <= 1'b1;
      @(posedge clk);
      mgmt_wr <= 1'b0;
      mgmt_addr <= ~a;
      mgmt_wdata <= ~d;
   endtask
   task rd(input logic [4:0] a);
      @(posedge clk);
      mgmt_addr <= a;
      mgmt_rd <= 1'b1;
      @(posedge clk);
      mgmt_rd <= 1'b0;
      mgmt_addr <= ~a;
   endtask
endmodule
`default_nettype wire

// ---- tb/autoneg_expansion_next_page_regs_test.sv ----
// self-checking bench for the expansion and next page transmit registers
`timescale 1ns/1ps
`default_nettype none
module autoneg_expansion_next_page_regs_test;
   import an_regs_pkg::*;
   logic        clk = 1'b0, arst_n = 1'b0, override_en = 1'b0, pd_fault_evt = 1'b0;
   logic        lp_page_stored = 1'b0, lp_more_pages = 1'b0, flp_valid = 1'b0;
   logic        base_page_sent = 1'b0, base_bit11 = 1'b0, np_page_sent = 1'b0;
   logic        mgmt_wr, mgmt_rd, np_tx_allowed, rd_seen = 1'b0, tgl = 1'b0;
   logic [4:0]  mgmt_addr;
   logic [15:0] mgmt_wdata, mgmt_rdata, np_tx_word, d;
   logic [15:0] exp_q[$];
   int          num_errors = 0, n_tests = 0;
   always #50 clk = ~clk;
   autoneg_expansion_next_page_regs dut_u (.*);
   mgmt_station sta_u (.*);
   // ----------------------------------------------------------------
   // checking
   // ----------------------------------------------------------------
   task chk(input string what, input logic [15:0] e, input logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, e, s);
      end
   endtask
   function logic [15:0] ex(input logic f, input logic n, input logic p, input logic a);
      return {11'h000, f, n, 1'b1, p, a};
   endfunction
   task rd(input logic [4:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      sta_u.rd(a);
   endtask
   // one-hot pulse of fault, page stored, base sent, next page sent
   task ev(input logic [3:0] m);
      @(posedge clk);
      {pd_fault_evt, lp_page_stored, base_page_sent, np_page_sent} <= m;
      @(posedge clk);
      {pd_fault_evt, lp_page_stored, base_page_sent, np_page_sent} <= 4'h0;
   endtask
   always @(posedge clk) rd_seen <= mgmt_rd;
   always @(negedge clk) if (rd_seen) chk("read data", exp_q.pop_front(), mgmt_rdata);
   task wrap_up;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      num_errors++;
      wrap_up;
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(90));
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      chk("tx word", 16'h2001, np_tx_word);
      chk("allowed", 16'h0000, {15'h0000, np_tx_allowed});
      rd(EXPANSION_ADDR, ex(0, 0, 0, 0));
      rd(NP_TRANSMIT_ADDR, 16'h2001);
      rd(5'h05, 16'h0000);
      repeat (4) begin
         d = 16'($urandom());
         sta_u.wr(NP_TRANSMIT_ADDR, d);
         d = {d[15], 1'b0, d[13:12], tgl, d[10:0]};
         rd(NP_TRANSMIT_ADDR, d);
         chk("tx word", d, np_tx_word);
      end
      for (int i = 0; i < 2; i++) begin
         override_en <= i[0];
         sta_u.wr(EXPANSION_ADDR, 16'hFFE0);
         rd(EXPANSION_ADDR, ex(0, 0, 0, 0));
      end
      ev(4'h8);
      rd(EXPANSION_ADDR, ex(1, 0, 0, 0));
      rd(EXPANSION_ADDR, ex(0, 0, 0, 0));
      lp_more_pages <= 1'b1;
      flp_valid <= 1'b1;
      ev(4'h4);
      rd(EXPANSION_ADDR, ex(0, 1, 1, 1));
      rd(EXPANSION_ADDR, ex(0, 1, 0, 1));
      chk("allowed", 16'h0001, {15'h0000, np_tx_allowed});
      pd_fault_evt <= 1'b1;
      rd(EXPANSION_ADDR, ex(1, 1, 0, 1));
      rd(EXPANSION_ADDR, ex(1, 1, 0, 1));
      pd_fault_evt <= 1'b0;
      // base page loads the inverse of its bit 11, each next page flips it
      for (int i = 0; i < 4; i++) begin
         base_bit11 <= i[1];
         ev(i[0] ? 4'h1 : 4'h2);
         tgl = i[0] ? ~tgl : ~i[1];
         // look one edge later: the toggle is launched at the edge ev returns on
         @(posedge clk);
         chk("toggle", {15'h0000, tgl}, {15'h0000, np_tx_word[NP_TOGGLE]});
      end
      // a partner page without the next page bit withdraws permission
      lp_more_pages <= 1'b0;
      ev(4'h4);
      @(posedge clk);
      chk("allowed", 16'h0000, {15'h0000, np_tx_allowed});
      wrap_up;
   end
endmodule
`default_nettype wire
